// *** rtl/ddr_quad_flash_dev.sv ***
// Flash end: byte array with per-unit correction and the DDR quad read engine.
// Assumes link pins are asynchronous and config inputs hold still during a read.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// What this block and the host end do
// [R1] EDh address length by select; EEh four bytes
// [R2] Quad read accepted only with four-line enable
// [R3] Address nibbles taken on both clock edges
// [R4] Data nibbles driven on both clock edges
// [R5] Host keeps clock at or below 80 MHz
// [R6] Dummy clocks equal latency code, inputs ignored
// [R7] Host floats lines through dummy with training
// [R8] Complementary mode nibbles enter continuous mode
// [R9] Other mode nibbles leave continuous mode
// [R10] Mode reset command leaves continuous mode
// [R11] Any start byte, address increments per byte
// [R12] Address wraps to zero past the top
// [R13] Host keeps select low through mode, dummy
// [R14] Training preamble in last four dummy clocks
// [R15] Pattern bit per edge on every line
// [R16] Host releases lines, trains capture per read
// [R17] Quad command mode: opcode nibble per rise
// [R18] Eight check bits plus disable per unit
// [R19] First program stores code, second disables
// [R20] Erase re-enables units except one-time area
// [R21] Enabled units read back corrected
// [R22] Page 256 or 512 bytes, aligned, wraps
// [R23] Lines driven only in preamble and data
module ddr_quad_flash_dev #(
  parameter int DEPTH = 1024,
  parameter int SECT_BYTES = 256,
  parameter int OTP_UNITS = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  flash_link_if.dev link,
  input wire logic four_line_enable_bit,
  input wire logic address_length_select,
  input wire logic quad_command_mode_select,
  input wire logic [3:0] latency_code,
  input wire logic page_size_select,
  input wire logic training_enable,
  input wire logic [7:0] capture_training_pattern,
  input wire logic prog_start,
  input wire logic [ddr_quad_pkg::ADDR_W-1:0] prog_addr,
  input wire logic prog_byte_valid,
  input wire logic [7:0] prog_byte,
  input wire logic prog_end,
  input wire logic erase_valid,
  input wire logic [ddr_quad_pkg::ADDR_W-1:0] erase_addr,
  input wire logic flip_valid,
  input wire logic [ddr_quad_pkg::ADDR_W-1:0] flip_bit,
  output logic cont_mode,
  output logic corrected
);
  import ddr_quad_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int UB = $clog2(UNIT_BYTES);
  localparam int UNITS = DEPTH / UNIT_BYTES;
  localparam int UW = UNIT_BYTES * 8;

  if (DEPTH < PAGE_LARGE || (DEPTH & (DEPTH - 1)) != 0 || DEPTH % SECT_BYTES != 0
      || SECT_BYTES % UNIT_BYTES != 0 || OTP_UNITS > UNITS) begin : g_bad_geometry
    $error("ddr_quad_flash_dev: unsupported array geometry");
  end

  typedef enum logic [2:0] {D_IDLE, D_OPC, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_SKIP} dev_phase_t;

  // Code position of data bit i: skips powers of two so a check-bit hit flips no data
  function automatic logic [CHECK_BITS-1:0] code_pos(input int i);
    int n;
    n = 0;
    for (int p = 3; p < 256; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == i) return CHECK_BITS'(p);
        n++;
      end
    end
    return '0;
  endfunction

  function automatic logic [CHECK_BITS-1:0] check_of(input logic [UW-1:0] bits);
    logic [CHECK_BITS-1:0] c;
    c = '0;
    for (int i = 0; i < UW; i++) begin
      if (bits[i]) c = c ^ code_pos(i);
    end
    return c;
  endfunction

  logic [2:0] sck_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [3:0] io_s1_reg;
  logic [3:0] io_s2_reg;
  dev_phase_t phase_reg;
  logic [5:0] ecnt_reg;
  logic [7:0] opc_reg;
  logic [31:0] addr_reg;
  logic [7:0] mode_reg;
  logic four_reg;
  logic cont_reg;
  logic [AW-1:0] rd_addr_reg;
  logic [3:0] dout_reg;
  logic [3:0] doe_reg;
  logic corrected_reg;
  logic [7:0] mem_reg [DEPTH];
  logic [UNITS-1:0] prog_reg;
  logic [UNITS-1:0] dis_reg;
  logic [CHECK_BITS-1:0] chk_reg [UNITS];
  logic pact_reg;
  logic psel_reg;
  logic [AW-1:0] pbase_reg;
  logic [8:0] poff_reg;
  logic [UNITS-1:0] touched_reg;

  logic sck_edge;
  logic sck_rise;
  logic cs_low;
  logic [7:0] mode_in;
  logic [5:0] pre_idx;
  logic [AW-UB-1:0] ru;
  logic [UW-1:0] ru_bits;
  logic [UW-1:0] ru_fixed;
  logic [CHECK_BITS-1:0] syn;
  logic [7:0] rd_byte;
  logic fix_hit;
  logic [AW-1:0] pa;
  int esec;

  // Clock edges come from the second and third sck stages; select and data use only the second stage
  assign sck_edge = sck_sync_reg[1] ^ sck_sync_reg[2];
  assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  assign cs_low = ~cs_sync_reg[1];
  assign mode_in = {mode_reg[3:0], io_s2_reg};
  assign pre_idx = {1'b0, latency_code, 1'b0} - 6'd1 - ecnt_reg;
  assign esec = int'(erase_addr[AW-1:0]) / SECT_BYTES;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sck_sync_reg <= '0;
      cs_sync_reg <= '1;
      io_s1_reg <= '0;
      io_s2_reg <= '0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], link.sck};
      cs_sync_reg <= {cs_sync_reg[0], link.cs_n};
      io_s1_reg <= link.io;
      io_s2_reg <= io_s1_reg;
    end
  end

  // Read path: unit around the read pointer, corrected when enabled
  always_comb begin
    ru = rd_addr_reg[AW-1:UB];
    for (int b = 0; b < UNIT_BYTES; b++) ru_bits[b*8 +: 8] = mem_reg[int'(ru) * UNIT_BYTES + b];
    syn = check_of(ru_bits) ^ chk_reg[ru];
    ru_fixed = ru_bits;
    if (prog_reg[ru] && !dis_reg[ru]) begin
      for (int i = 0; i < UW; i++) begin
        if (syn == code_pos(i)) ru_fixed[i] = ~ru_bits[i]; // R21
      end
    end
    rd_byte = ru_fixed[rd_addr_reg[UB-1:0]*8 +: 8];
    fix_hit = rd_byte != mem_reg[rd_addr_reg];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_reg <= D_IDLE;
      ecnt_reg <= '0;
      opc_reg <= '0;
      addr_reg <= '0;
      mode_reg <= '0;
      four_reg <= 1'b0;
      cont_reg <= 1'b0;
      rd_addr_reg <= '0;
    end else if (!cs_low) begin
      phase_reg <= D_IDLE;
      ecnt_reg <= '0;
    end else if (phase_reg == D_IDLE) begin
      phase_reg <= cont_reg ? D_ADDR : D_OPC; // R8
      ecnt_reg <= '0;
    end else if (sck_edge) begin
      ecnt_reg <= ecnt_reg + 6'd1;
      case (phase_reg)
        D_OPC: begin
          if (sck_rise) begin
            opc_reg <= quad_command_mode_select ? {opc_reg[3:0], io_s2_reg} // R17
              : {opc_reg[6:0], io_s2_reg[0]};
          end
          if (ecnt_reg == (quad_command_mode_select ? 6'd3 : 6'd15)) begin
            ecnt_reg <= '0;
            phase_reg <= D_SKIP;
            if (four_line_enable_bit && (opc_reg == OP_DDR_QUAD || opc_reg == OP_DDR_QUAD_4B)) begin
              phase_reg <= D_ADDR; // R2
              four_reg <= opc_reg == OP_DDR_QUAD_4B || address_length_select; // R1
            end
            if (opc_reg == OP_MODE_RESET) cont_reg <= 1'b0; // R10
          end
        end
        D_ADDR: begin
          addr_reg <= {addr_reg[27:0], io_s2_reg}; // R3
          // Mode reset arrives as all-ones nibbles while opcodes are skipped
          if (cont_reg && ecnt_reg == 6'd1 && {addr_reg[3:0], io_s2_reg} == OP_MODE_RESET) begin
            cont_reg <= 1'b0; // R10
            phase_reg <= D_SKIP;
          end else if (ecnt_reg == (four_reg ? 6'd7 : 6'd5)) begin // R1
            ecnt_reg <= '0;
            phase_reg <= D_MODE;
          end
        end
        D_MODE: begin
          mode_reg <= mode_in;
          if (ecnt_reg == 6'd1) begin
            cont_reg <= mode_in[7:4] == ~mode_in[3:0]; // R8 R9
            rd_addr_reg <= addr_reg[AW-1:0]; // R11 R12
            ecnt_reg <= '0;
            phase_reg <= (latency_code == 4'd0) ? D_DATA : D_DUMMY;
          end
        end
        D_DUMMY: begin
          if (pre_idx == 6'd0) begin // R6
            ecnt_reg <= '0;
            phase_reg <= D_DATA;
          end
        end
        D_DATA: begin
          if (ecnt_reg[0]) rd_addr_reg <= rd_addr_reg + 1'b1; // R11 R12
        end
        default: ;
      endcase
    end
  end

  // Output stage runs one cycle behind the phase so it never races the host's turn-off
  always_ff @(posedge ref_clk) begin
    if (reset || !cs_low) begin
      dout_reg <= '0;
      doe_reg <= '0; // R23
    end else begin
      case (phase_reg)
        D_DUMMY: begin
          if (training_enable && pre_idx <= 6'(2 * PREAMBLE_CLKS - 1)) begin // R14
            dout_reg <= {4{capture_training_pattern[pre_idx[2:0]]}}; // R15
            doe_reg <= 4'hF;
          end else begin
            dout_reg <= '0;
            doe_reg <= '0;
          end
        end
        D_DATA: begin
          dout_reg <= ecnt_reg[0] ? rd_byte[3:0] : rd_byte[7:4]; // R4
          doe_reg <= 4'hF;
        end
        default: begin
          dout_reg <= '0;
          doe_reg <= '0; // R23
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) corrected_reg <= 1'b0;
    else corrected_reg <= sck_edge && cs_low && phase_reg == D_DATA && ecnt_reg[0] && fix_hit;
  end

  // Page load pointer: offset wraps inside an aligned page
  assign pa = pbase_reg | AW'(poff_reg & (psel_reg ? 9'h1FF : 9'h0FF)); // R22

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pact_reg <= 1'b0;
      psel_reg <= 1'b0;
      pbase_reg <= '0;
      poff_reg <= '0;
      touched_reg <= '0;
    end else if (prog_start) begin
      pact_reg <= 1'b1;
      psel_reg <= page_size_select; // R22
      pbase_reg <= prog_addr[AW-1:0] & ~AW'(page_size_select ? PAGE_LARGE - 1 : PAGE_SMALL - 1);
      poff_reg <= prog_addr[8:0];
      touched_reg <= '0;
    end else if (prog_end) begin
      pact_reg <= 1'b0;
    end else if (prog_byte_valid && pact_reg) begin
      poff_reg <= poff_reg + 9'd1;
      touched_reg[pa[AW-1:UB]] <= 1'b1;
    end
  end

  // Array resets to erased; one-time units are never erased
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int a = 0; a < DEPTH; a++) mem_reg[a] <= ERASED_BYTE;
    end else begin
      if (prog_byte_valid && pact_reg && !prog_start && !prog_end) mem_reg[pa] <= mem_reg[pa] & prog_byte;
      if (erase_valid) begin
        for (int a = 0; a < DEPTH; a++) begin
          if (a / SECT_BYTES == esec && a / UNIT_BYTES >= OTP_UNITS) mem_reg[a] <= ERASED_BYTE;
        end
      end
      if (flip_valid) mem_reg[flip_bit[AW+2:3]][flip_bit[2:0]] <= ~mem_reg[flip_bit[AW+2:3]][flip_bit[2:0]];
    end
  end

  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    logic [UW-1:0] g_unit_bits;
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        prog_reg[u] <= 1'b0;
        dis_reg[u] <= 1'b0;
        chk_reg[u] <= '0;
      end else if (erase_valid && u * UNIT_BYTES / SECT_BYTES == esec && u >= OTP_UNITS) begin
        prog_reg[u] <= 1'b0; // R20
        dis_reg[u] <= 1'b0;
      end else if (prog_end && pact_reg && touched_reg[u]) begin
        if (prog_reg[u]) begin
          dis_reg[u] <= 1'b1; // R19
        end else begin
          prog_reg[u] <= 1'b1;
          chk_reg[u] <= check_of(g_unit_bits); // R18 R19
        end
      end
    end
    always_comb begin
      for (int b = 0; b < UNIT_BYTES; b++) g_unit_bits[b*8 +: 8] = mem_reg[u * UNIT_BYTES + b];
    end
  end

  assign link.dev_io_out = dout_reg;
  assign link.dev_io_oe = doe_reg;
  assign cont_mode = cont_reg;
  assign corrected = corrected_reg;
endmodule // ddr_quad_flash_dev

// *** rtl/ddr_quad_pkg.sv ***
// Shared constants for the DDR quad read flash link and its array.
// Assumes both ends run from one 25 MHz ref_clk.
package ddr_quad_pkg;
  localparam int ADDR_W = 32;
  localparam logic [7:0] OP_DDR_QUAD = 8'hED;
  localparam logic [7:0] OP_DDR_QUAD_4B = 8'hEE;
  localparam logic [7:0] OP_MODE_RESET = 8'hFF;
  localparam logic [7:0] MODE_CONTINUE = 8'hA5;
  localparam logic [7:0] MODE_RELEASE = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int UNIT_BYTES = 16;
  localparam int CHECK_BITS = 8;
  localparam int PAGE_SMALL = 256;
  localparam int PAGE_LARGE = 512;
  localparam int PREAMBLE_CLKS = 4;
  localparam int CLK_PERIOD_PS = 40_000;
  localparam int SCK_MAX_MHZ = 80;
  localparam int SCK_MIN_PERIOD_PS = 1_000_000 / SCK_MAX_MHZ;
  localparam int SCK_HALF_NS = 400;
  // Least time, so rounded up
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// *** rtl/flash_link_if.sv ***
// Serial flash link: clock, select and four shared data lines.
// Assumes a pull-up keeps an undriven data line high.
`timescale 1ns/1ps
interface flash_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io;
  assign io = (dev_io_oe & dev_io_out) | (~dev_io_oe & host_io_oe & host_io_out)
    | (~dev_io_oe & ~host_io_oe);
  modport host (output sck, output cs_n, output host_io_out, output host_io_oe, input io);
  modport dev (input sck, input cs_n, input io, output dev_io_out, output dev_io_oe);
endinterface

// *** rtl/ddr_quad_flash_host.sv ***
// Controller end: makes the serial clock and runs one DDR quad read or one mode reset per request.
// Assumes the device end on flash_link_if and pins sampled through two flip-flops.
`timescale 1ns/1ps
module ddr_quad_flash_host #(
  parameter int HALF = ddr_quad_pkg::SCK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  flash_link_if.host link,
  input wire logic rd_start,
  input wire logic [ddr_quad_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [15:0] rd_len,
  input wire logic rd_four_byte_op,
  input wire logic rd_cont_req,
  input wire logic mode_reset_req,
  input wire logic address_length_select,
  input wire logic quad_command_mode_select,
  input wire logic [3:0] latency_code,
  input wire logic training_enable,
  input wire logic [7:0] capture_training_pattern,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic cont_active,
  output logic early_tap,
  output logic train_fail
);
  import ddr_quad_pkg::*;

  // Clock ceiling, and room for two sampling taps after the device's pin delay
  if (2 * HALF * CLK_PERIOD_PS < SCK_MIN_PERIOD_PS || HALF < 8 || HALF > 255) begin : g_bad_half
    $error("ddr_quad_flash_host: HALF out of range");
  end

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_OPC, H_ADDR, H_MODE, H_DUMMY, H_DATA, H_HOLD} host_phase_t;

  host_phase_t phase_reg;
  logic [7:0] cnt_reg;
  logic [5:0] ecnt_reg;
  logic sck_reg;
  logic csn_reg;
  logic [3:0] hout_reg;
  logic [3:0] hoe_reg;
  logic [7:0] opc_reg;
  logic [31:0] tx_reg;
  logic [7:0] mode_reg;
  logic [15:0] left_reg;
  logic four_reg;
  logic rst_reg;
  logic cont_reg;
  logic [3:0] io_s1_reg;
  logic [3:0] io_s2_reg;
  logic [3:0] early_reg;
  logic [3:0] hi_reg;
  logic late_bad_reg;
  logic early_bad_reg;
  logic tap_reg;
  logic fail_reg;
  logic busy_reg;
  logic [7:0] data_reg;
  logic valid_reg;
  logic tick;
  logic [5:0] pre_idx;
  logic [3:0] nib;
  logic pre_bit;

  assign tick = cnt_reg == 8'(HALF - 1);
  assign pre_idx = {1'b0, latency_code, 1'b0} - 6'd1 - ecnt_reg;
  assign nib = tap_reg ? early_reg : io_s2_reg;
  assign pre_bit = capture_training_pattern[pre_idx[2:0]];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      io_s1_reg <= '0;
      io_s2_reg <= '0;
      early_reg <= '0;
    end else begin
      io_s1_reg <= link.io;
      io_s2_reg <= io_s1_reg;
      if (cnt_reg == 8'(HALF - 3)) early_reg <= io_s2_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_reg <= H_IDLE;
      cnt_reg <= '0;
      ecnt_reg <= '0;
      sck_reg <= 1'b0;
      csn_reg <= 1'b1;
      opc_reg <= '0;
      tx_reg <= '0;
      mode_reg <= '0;
      left_reg <= '0;
      four_reg <= 1'b0;
      rst_reg <= 1'b0;
      cont_reg <= 1'b0;
      hi_reg <= '0;
      late_bad_reg <= 1'b0;
      early_bad_reg <= 1'b0;
      tap_reg <= 1'b0;
      fail_reg <= 1'b0;
      busy_reg <= 1'b0;
      data_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      cnt_reg <= (tick || phase_reg == H_IDLE) ? 8'd0 : cnt_reg + 8'd1;
      if (phase_reg == H_IDLE) begin
        if (mode_reset_req || (rd_start && rd_len != 16'd0)) begin
          rst_reg <= mode_reset_req;
          opc_reg <= mode_reset_req ? OP_MODE_RESET : (rd_four_byte_op ? OP_DDR_QUAD_4B : OP_DDR_QUAD);
          four_reg <= cont_reg ? four_reg : (rd_four_byte_op || address_length_select); // R1
          tx_reg <= mode_reset_req ? 32'hFFFF_FFFF
            : ((cont_reg ? four_reg : (rd_four_byte_op || address_length_select))
            ? rd_addr : {rd_addr[23:0], 8'h00});
          mode_reg <= rd_cont_req ? MODE_CONTINUE : MODE_RELEASE;
          left_reg <= rd_len;
          late_bad_reg <= 1'b0;
          early_bad_reg <= 1'b0;
          tap_reg <= 1'b0;
          csn_reg <= 1'b0;
          busy_reg <= 1'b1;
          phase_reg <= H_SETUP;
        end
      end else if (tick) begin
        ecnt_reg <= ecnt_reg + 6'd1;
        if (phase_reg != H_SETUP && phase_reg != H_HOLD) sck_reg <= ~sck_reg;
        case (phase_reg)
          H_SETUP: begin
            ecnt_reg <= '0;
            phase_reg <= cont_reg ? H_ADDR : H_OPC;
          end
          H_OPC: begin
            if (ecnt_reg == (quad_command_mode_select ? 6'd3 : 6'd15)) begin // R17
              ecnt_reg <= '0;
              if (rst_reg) cont_reg <= 1'b0;
              phase_reg <= rst_reg ? H_HOLD : H_ADDR;
            end
          end
          H_ADDR: begin
            tx_reg <= {tx_reg[27:0], 4'h0}; // R3
            if (rst_reg && ecnt_reg == 6'd1) begin
              cont_reg <= 1'b0;
              ecnt_reg <= '0;
              phase_reg <= H_HOLD;
            end else if (ecnt_reg == (four_reg ? 6'd7 : 6'd5)) begin
              ecnt_reg <= '0;
              phase_reg <= H_MODE;
            end
          end
          H_MODE: begin
            if (ecnt_reg == 6'd1) begin
              cont_reg <= mode_reg[7:4] == ~mode_reg[3:0];
              ecnt_reg <= '0;
              phase_reg <= (latency_code == 4'd0) ? H_DATA : H_DUMMY;
            end
          end
          H_DUMMY: begin
            // Preamble slot: check both taps against the pattern
            if (training_enable && pre_idx <= 6'(2 * PREAMBLE_CLKS - 1)) begin
              if (io_s2_reg != {4{pre_bit}}) late_bad_reg <= 1'b1; // R16
              if (early_reg != {4{pre_bit}}) early_bad_reg <= 1'b1;
            end
            if (pre_idx == 6'd0) begin // R6
              ecnt_reg <= '0;
              tap_reg <= training_enable && late_bad_reg && !early_bad_reg; // R16
              fail_reg <= training_enable && late_bad_reg && early_bad_reg;
              phase_reg <= H_DATA;
            end
          end
          H_DATA: begin
            hi_reg <= nib;
            if (ecnt_reg[0]) begin
              data_reg <= {hi_reg, nib}; // R4
              valid_reg <= 1'b1;
              left_reg <= left_reg - 16'd1;
              if (left_reg == 16'd1) begin
                ecnt_reg <= '0;
                phase_reg <= H_HOLD;
              end
            end
          end
          H_HOLD: begin
            // Select stays high a full half period so the device sees it
            csn_reg <= 1'b1;
            if (ecnt_reg == 6'd1) begin
              busy_reg <= 1'b0;
              phase_reg <= H_IDLE;
            end
          end
          default: phase_reg <= H_IDLE;
        endcase
      end
    end
  end

  // Drive lines only while sending; released for dummy and data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hout_reg <= '0;
      hoe_reg <= '0;
    end else begin
      case (phase_reg)
        H_OPC: begin
          hout_reg <= quad_command_mode_select ? (ecnt_reg[1] ? opc_reg[3:0] : opc_reg[7:4])
            : {3'b000, opc_reg[3'd7 - ecnt_reg[3:1]]};
          hoe_reg <= quad_command_mode_select ? 4'hF : 4'h1;
        end
        H_ADDR: begin
          hout_reg <= tx_reg[31:28];
          hoe_reg <= 4'hF;
        end
        H_MODE: begin
          hout_reg <= ecnt_reg[0] ? mode_reg[3:0] : mode_reg[7:4];
          hoe_reg <= 4'hF;
        end
        default: begin
          hout_reg <= '0;
          hoe_reg <= '0; // R7 R16
        end
      endcase
    end
  end

  assign link.sck = sck_reg; // R5
  assign link.cs_n = csn_reg; // R13
  assign link.host_io_out = hout_reg;
  assign link.host_io_oe = hoe_reg;
  assign busy = busy_reg;
  assign rd_data = data_reg;
  assign rd_valid = valid_reg;
  assign cont_active = cont_reg;
  assign early_tap = tap_reg;
  assign train_fail = fail_reg;
endmodule // ddr_quad_flash_host

// *** verif/ddr_quad_assertions.sv ***
// Link checker for the host and device ends of the quad flash link.
// Assumes it watches the one flash_link_if of the bench, host HALF of 8.
`timescale 1ns/1ps
module ddr_quad_assertions (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] host_io_out,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Eight cycles is the shortest legal sck half period
  sequence s_low8; !sck [*8]; endsequence
  property p_half; $changed(sck) |=> $stable(sck) [*7]; endproperty
  a_half: assert property (p_half) else $error("sck half period short");
  property p_start; $fell(cs_n) |-> s_low8; endproperty
  a_start: assert property (p_start) else $error("sck moved early in select");
  property p_sel; $changed(sck) |-> !cs_n; endproperty
  a_sel: assert property (p_sel) else $error("sck moved outside select");
  property p_rel; $rose(cs_n) |-> ##4 (dev_io_oe == 4'h0); endproperty
  a_rel: assert property (p_rel) else $error("device drives after select");
  property p_drv; $rose(|dev_io_oe) |-> !cs_n; endproperty
  a_drv: assert property (p_drv) else $error("device drive unselected");
  property p_fight; (dev_io_oe != 4'h0) |-> (host_io_oe == 4'h0); endproperty
  a_fight: assert property (p_fight) else $error("both ends drive");
  property p_all; dev_io_oe inside {4'h0, 4'hF}; endproperty
  a_all: assert property (p_all) else $error("device lines split");
  property p_hoe; host_io_oe inside {4'h0, 4'h1, 4'hF}; endproperty
  a_hoe: assert property (p_hoe) else $error("host enable pattern bad");
endmodule // ddr_quad_assertions

// *** verif/tb_ddr_quad_read_and_ecc_program.sv ***
// Bench joining host and device ends over flash_link_if.
// Assumes a 25 MHz ref_clk and host sck half period of 8 cycles.
`timescale 1ns/1ps
module tb_ddr_quad_read_and_ecc_program;
  import ddr_quad_pkg::*;
  logic ref_clk, reset, four_line_enable_bit, address_length_select, quad_command_mode_select;
  logic training_enable, prog_start, prog_byte_valid, prog_end, erase_valid, flip_valid;
  logic rd_start, rd_four_byte_op, rd_cont_req, mode_reset_req, busy, rd_valid, cont_mode;
  logic corrected, train_fail;
  logic [3:0] latency_code;
  logic [7:0] prog_byte, rd_data;
  logic [31:0] prog_addr, erase_addr, flip_bit, rd_addr;
  logic [15:0] rd_len;
  wire logic page_size_select = 1'b0;
  wire logic [7:0] capture_training_pattern = 8'h34;
  logic [7:0] mem [1024];
  logic [7:0] q [$];
  int errors, n_checks, ncor;
  flash_link_if link ();
  ddr_quad_flash_dev i_ddr_quad_flash_dev (.ref_clk, .reset, .link, .four_line_enable_bit,
    .address_length_select, .quad_command_mode_select, .latency_code, .page_size_select,
    .training_enable, .capture_training_pattern, .prog_start, .prog_addr, .prog_byte_valid,
    .prog_byte, .prog_end, .erase_valid, .erase_addr, .flip_valid, .flip_bit, .cont_mode,
    .corrected);
  ddr_quad_flash_host #(.HALF(8)) i_ddr_quad_flash_host (.ref_clk, .reset, .link, .rd_start,
    .rd_addr, .rd_len, .rd_four_byte_op, .rd_cont_req, .mode_reset_req, .address_length_select,
    .quad_command_mode_select, .latency_code, .training_enable, .capture_training_pattern,
    .busy, .rd_data, .rd_valid, .cont_active(), .early_tap(), .train_fail);
  ddr_quad_assertions i_ddr_quad_assertions (.ref_clk, .reset, .sck(link.sck),
    .cs_n(link.cs_n), .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe),
    .dev_io_out(link.dev_io_out), .dev_io_oe(link.dev_io_oe), .io(link.io));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) q.push_back(rd_data);
    if (corrected === 1'b1) ncor++;
  end
  task automatic conclude;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Busy is read before the edge lands, so each look is settled
  task automatic wt;
    int k;
    k = 0;
    @(posedge ref_clk);
    while (busy !== 1'b0 && k < 9000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 9000) errors++;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [31:0] a, input int n, input logic f, input logic c);
    logic [31:0] x;
    q.delete();
    rd_addr <= a;
    rd_len <= 16'(n);
    rd_four_byte_op <= f;
    rd_cont_req <= c;
    rd_start <= 1'b1;
    @(posedge ref_clk);
    rd_start <= 1'b0;
    wt();
    for (int i = 0; i < n; i++) begin
      x = a + 32'(i);
      chk("rd_data", four_line_enable_bit ? mem[x[9:0]] : 8'hFF, q[i]);
    end
  endtask
  task automatic prog(input logic [31:0] a, input int n, input logic [7:0] k);
    logic [31:0] x;
    prog_addr <= a;
    prog_start <= 1'b1;
    @(posedge ref_clk);
    prog_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      x = a + 32'(i);
      prog_byte <= k | (x[7:0] ^ 8'hC3);
      prog_byte_valid <= 1'b1;
      mem[x[9:0]] &= k | (x[7:0] ^ 8'hC3);
      @(posedge ref_clk);
    end
    prog_byte_valid <= 1'b0;
    prog_end <= 1'b1;
    @(posedge ref_clk);
    prog_end <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_ecc;
    prog(32'h0000_0200, 16, 8'h00);
    prog(32'h0000_0000, 4, 8'h00);
    rd(32'h0000_0200, 16, 1'b0, 1'b0);
    flip_bit <= 32'h0000_1018;
    flip_valid <= 1'b1;
    @(posedge ref_clk);
    flip_valid <= 1'b0;
    ncor = 0;
    rd(32'h0000_0200, 4, 1'b0, 1'b0);
    chk("corrected", 8'h01, ncor[7:0]);
    prog(32'h0000_0203, 1, 8'hFF);
    mem[10'h203] ^= 8'h01;
    rd(32'h0000_0200, 4, 1'b0, 1'b0);
    erase_addr <= 32'h0000_0200;
    erase_valid <= 1'b1;
    @(posedge ref_clk);
    erase_addr <= 32'h0000_0000;
    @(posedge ref_clk);
    erase_valid <= 1'b0;
    for (int i = 0; i < 256; i++) mem[10'h200 + 10'(i)] = 8'hFF;
    rd(32'h0000_0200, 4, 1'b0, 1'b0);
    rd(32'h0000_0000, 4, 1'b0, 1'b0);
  endtask
  task automatic t_modes;
    for (int j = 0; j < 2; j++) begin
      address_length_select <= j[0];
      rd(32'h0000_03FE, 4, !j[0], 1'b0);
    end
    address_length_select <= 1'b0;
    rd(32'h0000_0000, 2, 1'b0, 1'b1);
    chk("cont_mode", 8'h01, {7'h0, cont_mode});
    rd(32'h0000_0001, 2, 1'b0, 1'b1);
    rd(32'h0000_0000, 2, 1'b0, 1'b0);
    chk("cont_mode", 8'h00, {7'h0, cont_mode});
    rd(32'h0000_0000, 2, 1'b0, 1'b1);
    mode_reset_req <= 1'b1;
    @(posedge ref_clk);
    mode_reset_req <= 1'b0;
    wt();
    chk("cont_mode", 8'h00, {7'h0, cont_mode});
  endtask
  task automatic t_quad;
    quad_command_mode_select <= 1'b1;
    training_enable <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      latency_code <= 4'h4 + 4'(5 * j);
      rd(32'h0000_0000, 4, 1'b1, 1'b0);
      chk("train_fail", 8'h00, {7'h0, train_fail});
    end
    quad_command_mode_select <= 1'b0;
    training_enable <= 1'b0;
    four_line_enable_bit <= 1'b0;
    rd(32'h0000_0000, 2, 1'b0, 1'b0);
    four_line_enable_bit <= 1'b1;
  endtask
  initial begin
    #1_000_000;
    errors++;
    conclude();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {prog_start, prog_byte_valid, prog_end, erase_valid, flip_valid, rd_start} = '0;
    {mode_reset_req, quad_command_mode_select, training_enable, rd_cont_req} = '0;
    {address_length_select, rd_four_byte_op, prog_byte, prog_addr, erase_addr} = '0;
    {flip_bit, rd_addr, rd_len} = '0;
    four_line_enable_bit = 1'b1;
    latency_code = 4'h6;
    reset = 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_ecc();
    t_modes();
    t_quad();
    conclude();
  end
endmodule // tb_ddr_quad_read_and_ecc_program
